// [hdl/frt_capture.sv]
`timescale 1ns/1ps
module frt_capture (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    // Pin and settings
    input  wire logic                      cap_in,
    input  wire logic [1:0]                edge_sel,
    input  wire logic [frt_pkg::CNT_W-1:0] count,
    // Result
    output logic      [frt_pkg::CNT_W-1:0] cap_val,
    output logic                           cap_evt
);
    import frt_pkg::*;

    typedef struct packed {
        logic             armed;
        logic             prev;
        logic [CNT_W-1:0] val;
    } frt_cap_type;

    frt_cap_type s;
    frt_cap_type next_s;
    logic        hit;

    // ----------------------------------------
    // Edge detect
    // ----------------------------------------
    // Armed stops the pin level at reset release from posing as an edge
    always_comb begin
        next_s       = s;
        next_s.armed = 1'b1;
        next_s.prev  = cap_in;
        hit = s.armed && (s.prev != cap_in) &&
              ((cap_in && (edge_sel == EDGE_RISE ||
                           edge_sel == EDGE_BOTH)) ||
               (!cap_in && (edge_sel == EDGE_FALL ||
                            edge_sel == EDGE_BOTH)));
        if (hit) begin
            next_s.val = count;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cap_val = s.val;
    // Event leaves with the copy so value and flag land on one edge
    assign cap_evt = hit;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_cap_val;
        @(posedge clk_sys) disable iff (!rst_b)
        hit |=> cap_val == $past(count);
    endproperty
    a_cap_val: assert property (p_cap_val)
        else $error("capture value not the count at the edge");

    property p_cap_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        !hit |=> $stable(cap_val);
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("capture register changed without an edge");

    property p_cap_rise;
        @(posedge clk_sys) disable iff (!rst_b)
        s.armed && edge_sel == EDGE_RISE && !s.prev && cap_in
        |=> cap_val == $past(count);
    endproperty
    a_cap_rise: assert property (p_cap_rise)
        else $error("rising edge not captured");

    c_cap_both: cover property (@(posedge clk_sys) disable iff (!rst_b)
        edge_sel == EDGE_BOTH && cap_evt ##[1:20] cap_evt);
endmodule

// [hdl/frt_pkg.sv]
package frt_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 6;
    localparam int NUM_CH = 2;
    localparam int NUM_EV = 5;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_COUNT  = 8'h04;
    localparam logic [7:0] A_CMP0   = 8'h08;
    localparam logic [7:0] A_CMP1   = 8'h0C;
    localparam logic [7:0] A_OUT    = 8'h10;
    localparam logic [7:0] A_CAPCTL = 8'h14;
    localparam logic [7:0] A_CAP0   = 8'h18;
    localparam logic [7:0] A_CAP1   = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;
    localparam logic [7:0] A_MASK   = 8'h24;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_CKS   = 0;
    localparam int CTRL_CLRM  = 2;
    localparam int CTRL_PAIR  = 3;
    localparam int CTRL_SWCLR = 4;
    localparam int ST_OVF     = 0;
    localparam int ST_CMP0    = 1;
    localparam int ST_CMP1    = 2;
    localparam int ST_CAP0    = 3;

    // ----------------------------------------
    // Codes and reset values
    // ----------------------------------------
    localparam logic [1:0] CKS_DIV4  = 2'b00;
    localparam logic [1:0] CKS_DIV16 = 2'b01;
    localparam logic [1:0] CKS_DIV32 = 2'b10;
    localparam logic [1:0] EDGE_OFF  = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;

    // Prescaler bits that must all be set for one count tick
    function automatic logic [5:0] frt_div_mask(input logic [1:0] cks);
        case (cks)
            CKS_DIV4:  frt_div_mask = 6'h03;
            CKS_DIV16: frt_div_mask = 6'h0F;
            CKS_DIV32: frt_div_mask = 6'h1F;
            default:   frt_div_mask = 6'h3F;
        endcase
    endfunction
endpackage

// [hdl/frt_top.sv]
`timescale 1ns/1ps
// How it works
// - 16-bit up counter runs freely on ticks
// - Tick is clock divided by 4/16/32/64
// - Interrupt on overflow and on each compare match
// - Counter cleared by reset, software, compare 0
// - Counter value feeds every compare and capture
// - Match inverts output pin and flags interrupt
// - Two compare channels, own pin and flag
// - Pair mode: either match inverts one pin
// - Software presets each compare output level
// - Valid edge copies counter, flags interrupt
// - Edge select: rising, falling or both
// - Two independent capture channels and settings
module frt_top (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_b,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [frt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [frt_pkg::DATA_W-1:0] pwdata,
    output logic      [frt_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Capture inputs and compare outputs
    input  wire logic [frt_pkg::NUM_CH-1:0] cap_in,
    output logic      [frt_pkg::NUM_CH-1:0] cmp_out,
    // Interrupt
    output logic                            irq
);
    import frt_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0]  pre;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  cmp0;
        logic [CNT_W-1:0]  cmp1;
        logic [1:0]        cks;
        logic              clr_m0;
        logic              pair;
        logic [NUM_CH-1:0] out;
        logic [3:0]        edges;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] mask;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
    } frt_state_type;

    frt_state_type                s;
    frt_state_type                next_s;
    logic [NUM_CH-1:0][CNT_W-1:0] cap_val;
    logic [NUM_CH-1:0]            cap_evt;
    logic                         tick;
    logic                         m0;
    logic                         m1;
    logic                         ovf;
    logic                         wr_en;
    logic                         wr_swclr;
    logic                         wr_out;
    logic [DATA_W-1:0]            rd;
    logic                         rd_ok;
    logic [NUM_EV-1:0]            ev;
    logic [NUM_EV-1:0]            st_clr;

    // ----------------------------------------
    // Capture channels
    // ----------------------------------------
    // One instance per pin, each with its own edge field
    for (genvar i = 0; i < NUM_CH; i++) begin : g_cap
        frt_capture u_cap (
            .clk_sys  (clk_sys),
            .rst_b    (rst_b),
            .cap_in   (cap_in[i]),
            .edge_sel (s.edges[2*i+1 -: 2]),
            .count    (s.cnt),
            .cap_val  (cap_val[i]),
            .cap_evt  (cap_evt[i])
        );
    end

    // ----------------------------------------
    // Time base events
    // ----------------------------------------
    assign tick = (s.pre & frt_div_mask(s.cks)) ==
                  frt_div_mask(s.cks);
    assign m0   = tick && (s.cnt == s.cmp0);
    assign m1   = tick && (s.cnt == s.cmp1);
    assign ovf  = tick && (s.cnt == CNT_MAX);
    assign ev   = {cap_evt, m1, m0, ovf};

    // ----------------------------------------
    // Bus strobes
    // ----------------------------------------
    // A write lands only at the edge that samples pready high
    assign wr_en    = psel && penable && s.pready && pwrite;
    assign wr_swclr = wr_en && paddr == A_CTRL && pwdata[CTRL_SWCLR];
    assign wr_out   = wr_en && paddr == A_OUT;
    // Only bits shown by the read are cleared, later events survive
    assign st_clr   = (psel && penable && s.pready && !pwrite &&
                       paddr == A_STATUS) ? s.prdata[NUM_EV-1:0]
                                          : '0;

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        rd    = '0;
        rd_ok = 1'b1;
        case (paddr)
            A_CTRL:   rd = {27'h000_0000, 1'b0, s.pair, s.clr_m0,
                            s.cks};
            A_COUNT:  rd = {16'h0000, s.cnt};
            A_CMP0:   rd = {16'h0000, s.cmp0};
            A_CMP1:   rd = {16'h0000, s.cmp1};
            A_OUT:    rd = {30'h0000_0000, s.out};
            A_CAPCTL: rd = {28'h000_0000, s.edges};
            A_CAP0:   rd = {16'h0000, cap_val[0]};
            A_CAP1:   rd = {16'h0000, cap_val[1]};
            A_STATUS: rd = {27'h000_0000, s.status};
            A_MASK:   rd = {27'h000_0000, s.mask};
            default:  rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s         = s;
        next_s.pre     = s.pre + 6'h01;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        if (tick) begin
            if (m0 && s.clr_m0) begin
                next_s.cnt = CNT_RST;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end
        next_s.out[0] = s.out[0] ^ m0;
        next_s.out[1] = s.out[1] ^ (m1 || (s.pair && m0));
        // Set beats clear when both land together
        next_s.status = (s.status & ~st_clr) | ev;

        // One wait state: answer registered in the first access cycle
        if (psel && penable && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.prdata  = rd;
            next_s.pslverr = !rd_ok;
        end

        if (wr_en) begin
            case (paddr)
                A_CTRL: begin
                    next_s.cks    = pwdata[CTRL_CKS +: 2];
                    next_s.clr_m0 = pwdata[CTRL_CLRM];
                    next_s.pair   = pwdata[CTRL_PAIR];
                end
                A_CMP0:   next_s.cmp0  = pwdata[CNT_W-1:0];
                A_CMP1:   next_s.cmp1  = pwdata[CNT_W-1:0];
                A_OUT:    next_s.out   = pwdata[NUM_CH-1:0];
                A_CAPCTL: next_s.edges = pwdata[3:0];
                A_MASK:   next_s.mask  = pwdata[NUM_EV-1:0];
                default:  ;
            endcase
        end
        // Software clear overrides a tick in the same cycle
        if (wr_swclr) begin
            next_s.cnt = CNT_RST;
        end
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign cmp_out = s.out;
    assign irq     = s.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_count_up;
        @(posedge clk_sys) disable iff (!rst_b)
        tick && !(m0 && s.clr_m0) && !wr_swclr
        |=> s.cnt == $past(s.cnt) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not step on tick");

    property p_count_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        !tick && !wr_swclr |=> $stable(s.cnt);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter moved without tick");

    property p_div4;
        @(posedge clk_sys) disable iff (!rst_b)
        tick && s.cks == CKS_DIV4 && !wr_en
        |=> !tick [*3] ##1 (tick || s.cks != CKS_DIV4);
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by four tick spacing wrong");

    property p_ovf;
        @(posedge clk_sys) disable iff (!rst_b)
        ovf |=> s.cnt == CNT_RST && s.status[ST_OVF];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow did not wrap or flag");

    property p_clr_match;
        @(posedge clk_sys) disable iff (!rst_b)
        m0 && s.clr_m0 |=> s.cnt == CNT_RST && s.status[ST_CMP0];
    endproperty
    a_clr_match: assert property (p_clr_match)
        else $error("compare 0 match did not clear counter");

    property p_swclr;
        @(posedge clk_sys) disable iff (!rst_b)
        wr_swclr |=> s.cnt == CNT_RST;
    endproperty
    a_swclr: assert property (p_swclr)
        else $error("software clear ignored");

    property p_toggle;
        @(posedge clk_sys) disable iff (!rst_b)
        m0 && !wr_out |=> cmp_out[0] != $past(cmp_out[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("compare 0 output did not invert");

    property p_pair;
        @(posedge clk_sys) disable iff (!rst_b)
        s.pair && m0 && !m1 && !wr_out
        |=> cmp_out[1] != $past(cmp_out[1]);
    endproperty
    a_pair: assert property (p_pair)
        else $error("paired output did not invert");

    property p_preset;
        @(posedge clk_sys) disable iff (!rst_b)
        wr_out |=> cmp_out == $past(pwdata[NUM_CH-1:0]);
    endproperty
    a_preset: assert property (p_preset)
        else $error("output preset not applied");

    property p_irq;
        @(posedge clk_sys) disable iff (!rst_b)
        irq == |(s.status & s.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow status and mask");

    property p_ready;
        @(posedge clk_sys) disable iff (!rst_b)
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("bus answer not one wait state");

    property p_m1;
        @(posedge clk_sys) disable iff (!rst_b)
        m1 && !wr_out |=> cmp_out[1] != $past(cmp_out[1]);
    endproperty
    a_m1: assert property (p_m1)
        else $error("compare 1 output did not invert");

    property p_irq_evt;
        @(posedge clk_sys) disable iff (!rst_b)
        (|(ev & s.mask)) && !(wr_en && paddr == A_MASK) |=> irq;
    endproperty
    a_irq_evt: assert property (p_irq_evt)
        else $error("unmasked event raised no interrupt");

    // Bits shown by a status read are gone after it, unless set again
    property p_rd_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_clr & ~ev) != '0
        |=> (s.status & $past(st_clr & ~ev)) == '0;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status read did not clear its bits");

    property p_slverr;
        @(posedge clk_sys) disable iff (!rst_b)
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error answer without ready or with data");

    c_ovf: cover property (@(posedge clk_sys) disable iff (!rst_b)
        ovf);
    c_pair: cover property (@(posedge clk_sys) disable iff (!rst_b)
        s.pair && m0 ##[1:200] m1);
    c_clrm: cover property (@(posedge clk_sys) disable iff (!rst_b)
        m0 && s.clr_m0 ##[1:400] m0);
endmodule

// [verification/frt_pin_model.sv]
`timescale 1ns/1ps
module frt_pin_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Pins of the timer
    input  wire logic [1:0] cmp_out,
    output logic      [1:0] cap_in
);
    int unsigned n_tog [2];
    logic [1:0]  last_out;

    initial cap_in = 2'b00;

    // External source holds its level until told to move it
    task automatic set_pin(input int ch, input logic val);
        @(posedge clk_sys);
        cap_in[ch] <= val;
    endtask

    // Cleared on the falling edge so it never races the counting below
    task automatic clr_tog();
        @(negedge clk_sys);
        n_tog[0] = 0;
        n_tog[1] = 0;
    endtask

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_out <= 2'b00;
        end else begin
            last_out <= cmp_out;
            for (int i = 0; i < 2; i++) begin
                if (cmp_out[i] !== last_out[i]) n_tog[i]++;
            end
        end
    end
endmodule

// [verification/tb_free_run_timer_compare_capture.sv]
`timescale 1ns/1ps
module tb_free_run_timer_compare_capture;
    import frt_pkg::*;

    localparam logic [7:0] A_BAD   = 8'h28;
    localparam int         CYC_MAX = 40000;

    logic        clk_sys;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  cap_in;
    logic [1:0]  cmp_out;
    logic        irq;
    int          n_fail;
    int          total_checks;
    int          cyc;
    logic [31:0] v;
    logic [31:0] v2;
    logic [31:0] c0;
    logic        e;
    int          divs [4] = '{4, 16, 32, 64};
    logic [7:0]  zadr [9] = '{A_CTRL, A_CMP0, A_CMP1, A_OUT, A_CAPCTL,
                              A_CAP0, A_CAP1, A_STATUS, A_MASK};
    // Both compares sit at 0 with the count, so the first tick matches
    logic [31:0] zexp [9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                              32'h0000_0003, 32'h0000_0000, 32'h0000_0000,
                              32'h0000_0000, 32'h0000_0006, 32'h0000_0000};

    frt_top frt_top_i (
        .clk_sys (clk_sys), .rst_b (rst_b), .psel (psel),
        .penable (penable), .pwrite (pwrite), .paddr (paddr),
        .pwdata  (pwdata), .prdata (prdata), .pready (pready),
        .pslverr (pslverr), .cap_in (cap_in), .cmp_out (cmp_out),
        .irq     (irq)
    );

    frt_pin_model frt_pin_model_i (
        .clk_sys (clk_sys), .rst_b (rst_b), .cmp_out (cmp_out),
        .cap_in  (cap_in)
    );

    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
                           input logic [31:0] hi);
        total_checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == CYC_MAX) begin
            n_fail++;
            end_sim();
        end
    end

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic x;
        apb(1'b0, a, 32'h0000_0000, d, x);
    endtask

    task automatic wait_irq();
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 200) begin
            @(posedge clk_sys);
            i++;
        end
        chk({31'b0, irq}, 32'h0000_0001);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (zadr[i]) begin
            rd(zadr[i], v);
            chk(v, zexp[i]);
        end
        rd(A_COUNT, v);
        chk_rng(v, 32'h0000_0000, 32'h0000_0040);
        apb(1'b0, A_BAD, 32'h0000_0000, v, e);
        chk({31'b0, e}, 32'h0000_0001);
        chk(v, 32'h0000_0000);
        $display("test reset done");

        // Each select, cleared then left to run for 16 ticks
        for (int k = 0; k < 4; k++) begin
            wr(A_CTRL, 32'h0000_0010 | k);
            repeat (16 * divs[k]) @(posedge clk_sys);
            rd(A_COUNT, v);
            chk_rng(v, 32'h0000_000F, 32'h0000_0012);
        end
        $display("test prescaler done");

        wr(A_MASK, 32'h0000_0002);
        wr(A_CMP0, 32'h0000_0003);
        wr(A_CMP1, 32'h0000_0001);
        // Cleared first, else the count climbs to the wrap before matching
        // Period is 4 ticks of 4 cycles, 20 periods per window
        for (int p = 0; p < 2; p++) begin
            wr(A_CTRL, 32'h0000_0014 | (p << 3));
            frt_pin_model_i.clr_tog();
            repeat (320) @(posedge clk_sys);
            chk_rng(frt_pin_model_i.n_tog[0], 19, 21);
            chk_rng(frt_pin_model_i.n_tog[1], 20 * p + 19,
                    20 * p + 21);
            rd(A_COUNT, v);
            chk_rng(v, 32'h0000_0000, 32'h0000_0003);
        end
        wait_irq();
        rd(A_STATUS, v);
        chk(v & 32'h0000_0002, 32'h0000_0002);
        $display("test compare done");

        // Matches parked far away so only software moves the pins
        wr(A_CTRL, 32'h0000_0013);
        wr(A_CMP0, 32'h0000_FFFF);
        wr(A_CMP1, 32'h0000_FFFF);
        wr(A_OUT, 32'h0000_0003);
        rd(A_OUT, v);
        chk(v, 32'h0000_0003);
        wr(A_OUT, 32'h0000_0001);
        @(posedge clk_sys);
        chk({30'b0, cmp_out}, 32'h0000_0001);
        wr(A_MASK, 32'h0000_0000);
        $display("test preset done");

        for (int code = 0; code < 4; code++) begin
            for (int dir = 0; dir < 2; dir++) begin
                wr(A_CAPCTL, code);
                frt_pin_model_i.set_pin(0, !dir);
                repeat (4) @(posedge clk_sys);
                rd(A_STATUS, v);
                frt_pin_model_i.set_pin(0, dir);
                repeat (4) @(posedge clk_sys);
                rd(A_STATUS, v);
                chk(v & 32'h0000_0018,
                    ((code == 1 && dir == 1) || (code == 2 && dir == 0)
                     || code == 3) ? 32'h0000_0008
                                   : 32'h0000_0000);
            end
        end
        wr(A_CAPCTL, 32'h0000_0009);
        frt_pin_model_i.set_pin(1, 1'b1);
        frt_pin_model_i.set_pin(0, 1'b0);
        rd(A_STATUS, v);
        chk(v & 32'h0000_0018, 32'h0000_0000);
        rd(A_COUNT, c0);
        frt_pin_model_i.set_pin(0, 1'b1);
        repeat (3) @(posedge clk_sys);
        rd(A_CAP0, v);
        rd(A_COUNT, v2);
        chk_rng(v, c0, v2);
        wr(A_CAP0, 32'h0000_0000);
        frt_pin_model_i.set_pin(0, 1'b0);
        repeat (40) @(posedge clk_sys);
        rd(A_CAP0, v2);
        chk(v2, v);
        rd(A_STATUS, v);
        wr(A_MASK, 32'h0000_0010);
        frt_pin_model_i.set_pin(1, 1'b0);
        wait_irq();
        rd(A_STATUS, v);
        chk(v & 32'h0000_0018, 32'h0000_0010);
        repeat (2) @(posedge clk_sys);
        chk({31'b0, irq}, 32'h0000_0000);
        $display("test capture done");
        end_sim();
    end
endmodule
